// ---- wake_on_radio_timer_test.sv ----
`timescale 1ns/1ps
module wake_on_radio_timer_test;
	logic       CLK, RESETN, WR_EN, WAKE_EVENT, RX_START_EVENT, OSC_ON;
	logic       CAL_BUSY;
	logic [5:0] ADDR;
	logic [7:0] WR_DATA, RD_DATA;
	int         err_count, total_checks, n;
	int         cyc = 0;
	wort_top u_wort_top (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
		.WR_EN(WR_EN), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
		.WAKE_EVENT(WAKE_EVENT), .RX_START_EVENT(RX_START_EVENT),
		.OSC_ON(OSC_ON), .CAL_BUSY(CAL_BUSY));
	////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %0h wanted %0h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WR_EN <= 1'b1;
		WR_DATA <= d;
		@(posedge CLK);
		WR_EN <= 1'b0;
	endtask : wr
	// read data is registered, so look one edge after the address
	task rd(input logic [5:0] a, input logic [31:0] e);
		@(posedge CLK);
		ADDR <= a;
		@(posedge CLK);
		#1 chk(RD_DATA, e);
	endtask : rd
	// cycles until the next pulse; bounded so a dead timer cannot hang
	task wt(input logic rx, input int e);
		n = 0;
		do begin
			@(posedge CLK);
			#1; // look after the edge so the pulse has settled
			n++;
		end while ((rx ? RX_START_EVENT : WAKE_EVENT) !== 1'b1 && n < 30000);
		if (e > 0) chk(n, e);
	endtask : wt
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	// ceiling sits well above the longest wake interval measured
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 80000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		RESETN = 1'b0;
		WR_EN = 1'b0;
		ADDR = 6'h00;
		WR_DATA = 8'h00;
		repeat (10) @(posedge CLK);
		RESETN <= 1'b1;
		rd(6'h1e, 8'h87);
		rd(6'h1f, 8'h6b);
		rd(6'h20, 8'hf8);
		wr(6'h20, 8'h0c);
		repeat (2) @(posedge CLK);
		#1 chk(CAL_BUSY, 1'b1);
		rd(6'h20, 8'h08);
		// calibration lasts four slow periods, 3000 cycles after the write
		repeat (2994) @(posedge CLK);
		#1 chk(CAL_BUSY, 1'b1);
		repeat (2) @(posedge CLK);
		#1 chk({OSC_ON, CAL_BUSY}, 2'h2);
		wr(6'h20, 8'h80);
		wr(6'h1e, 8'h00);
		wr(6'h1f, 8'h05);
		wr(6'h20, 8'h00);
		repeat (2) @(posedge CLK);
		#1 chk({OSC_ON, CAL_BUSY}, 2'h2);
		wt(1'b0, 0);
		wt(1'b1, 3000);
		wt(1'b0, 750);
		// coarse resolution, one count is 32 slow periods; bit 2 written
		// high must read back low; delay code 1 gives six periods
		wr(6'h1f, 8'h01);
		wr(6'h20, 8'h15);
		rd(6'h20, 8'h11);
		wt(1'b0, 0);
		wt(1'b1, 4500);
		wt(1'b0, 19500);
		wr(6'h21, 8'hff);
		rd(6'h21, 8'h00);
		give_verdict();
	end
endmodule : wake_on_radio_timer_test

// ---- wort_assertions.sv ----
`timescale 1ns/1ps
module wort_assertions (
	// clock and reset
	input wire logic       CLK,
	input wire logic       RESETN,
	// register port
	input wire logic [5:0] ADDR,
	input wire logic       WR_EN,
	input wire logic [7:0] WR_DATA,
	input wire logic [7:0] RD_DATA,
	// events and status
	input wire logic       WAKE_EVENT,
	input wire logic       RX_START_EVENT,
	input wire logic       OSC_ON,
	input wire logic       CAL_BUSY
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	logic ctrl_wr;
	// control writes drive every oscillator check below except a_cal_on
	assign ctrl_wr = WR_EN && ADDR == wort_pkg::ADDR_WAKE_CTRL;
	////////////////////////////////////////////////////////////////////
	a_bit2_zero: assert property (ADDR == 6'h20 |=> !RD_DATA[2])
		else $error("reserved control bit read as one");
	a_wake_pulse: assert property (WAKE_EVENT |=> !WAKE_EVENT)
		else $error("wake pulse longer than one cycle");
	a_rx_pulse: assert property (RX_START_EVENT |=> !RX_START_EVENT)
		else $error("receive start pulse longer than one cycle");
	a_rx_not_early: assert property (WAKE_EVENT |=> !RX_START_EVENT[*8])
		else $error("receive start too soon after wake");
	a_osc_up: assert property (ctrl_wr && !WR_DATA[7] && !OSC_ON
		|-> ##[1:2] OSC_ON) else $error("oscillator did not power up");
	a_osc_down: assert property (ctrl_wr && WR_DATA[7]
		|-> ##[1:2] !OSC_ON) else $error("oscillator did not power down");
	a_cal_start: assert property (ctrl_wr && WR_DATA[7:3] == 5'h01
		&& !OSC_ON |-> ##[1:2] CAL_BUSY) else $error("no calibration");
	a_cal_skip: assert property (ctrl_wr && WR_DATA[7:3] == 5'h00
		&& !OSC_ON |=> OSC_ON && !CAL_BUSY)
		else $error("calibration while disabled");
	a_cal_on: assert property (CAL_BUSY |-> OSC_ON)
		else $error("calibrating while powered down");
	c_wake: cover property (WAKE_EVENT);
	c_rx: cover property (RX_START_EVENT);
	c_cal: cover property (CAL_BUSY);
endmodule : wort_assertions

bind wort_top wort_assertions u_wort_assertions (.CLK(CLK), .RESETN(RESETN),
	.ADDR(ADDR), .WR_EN(WR_EN), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
	.WAKE_EVENT(WAKE_EVENT), .RX_START_EVENT(RX_START_EVENT),
	.OSC_ON(OSC_ON), .CAL_BUSY(CAL_BUSY));

// ---- wort_pkg.sv ----
package wort_pkg;
	// register offsets in the device map
	localparam logic [5:0] ADDR_WAKE_HIGH = 6'h1e;
	localparam logic [5:0] ADDR_WAKE_LOW  = 6'h1f;
	localparam logic [5:0] ADDR_WAKE_CTRL = 6'h20;

	// reset values
	localparam logic [7:0] RST_WAKE_HIGH = 8'h87;
	localparam logic [7:0] RST_WAKE_LOW  = 8'h6b;
	localparam logic       RST_PD        = 1'h1;
	localparam logic [2:0] RST_DELAY     = 3'h7;
	localparam logic       RST_CAL_EN    = 1'h1;
	localparam logic [1:0] RST_RES       = 2'h0;

	// wake_control field positions
	localparam int PD_BIT    = 7;
	localparam int DELAY_LSB = 4;
	localparam int CAL_BIT   = 3;
	localparam int RES_LSB   = 0;

	// slow clock is the crystal clock divided by this ratio
	localparam logic [9:0] SLOW_DIV = 10'h2ee;
	// length of the initial oscillator calibration, in slow periods
	localparam logic [3:0] CAL_PERIODS = 4'h4;

	// oscillator and timer state
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_CAL = 2'b01,
		ST_RUN = 2'b10
	} wort_state_t;

	// slow periods from wake event to receive start event
	function automatic logic [5:0] wort_delay(input logic [2:0] sel);
		case (sel)
			3'h0:    wort_delay = 6'h04;
			3'h1:    wort_delay = 6'h06;
			3'h2:    wort_delay = 6'h08;
			3'h3:    wort_delay = 6'h0c;
			3'h4:    wort_delay = 6'h10;
			3'h5:    wort_delay = 6'h18;
			3'h6:    wort_delay = 6'h20;
			default: wort_delay = 6'h30;
		endcase
	endfunction : wort_delay

	// last prescaler value: 2^(5*res) slow periods per count, minus one
	function automatic logic [14:0] wort_pre_last(input logic [1:0] res);
		case (res)
			2'h0:    wort_pre_last = 15'h0000;
			2'h1:    wort_pre_last = 15'h001f;
			2'h2:    wort_pre_last = 15'h03ff;
			default: wort_pre_last = 15'h7fff;
		endcase
	endfunction : wort_pre_last
endpackage : wort_pkg

// ---- wort_top.sv ----
`timescale 1ns/1ps
module wort_top (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RESETN,
	// register port
	input  wire logic [5:0] ADDR,
	input  wire logic       WR_EN,
	input  wire logic [7:0] WR_DATA,
	output logic      [7:0] RD_DATA,
	// timer events and oscillator status
	output logic            WAKE_EVENT,
	output logic            RX_START_EVENT,
	output logic            OSC_ON,
	output logic            CAL_BUSY
);

	////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]          hi_q, hi_d;
	logic [7:0]          lo_q, lo_d;
	logic                pd_q, pd_d;
	logic [2:0]          dly_sel_q, dly_sel_d;
	logic                cal_en_q, cal_en_d;
	logic [1:0]          res_q, res_d;
	wort_pkg::wort_state_t state_q, state_d;
	logic [9:0]          div_q, div_d;
	logic [3:0]          cal_q, cal_d;
	logic [14:0]         pre_q, pre_d;
	logic [15:0]         per_q, per_d;
	logic                d1_act_q, d1_act_d;
	logic [5:0]          d1_cnt_q, d1_cnt_d;
	logic [5:0]          d1_lim_q, d1_lim_d;
	logic                ev0_q, ev0_d;
	logic                ev1_q, ev1_d;
	logic [7:0]          rd_q, rd_d;
	logic                osc_q, osc_d;
	logic                busy_q, busy_d;

	logic                slow_tick;
	logic                wr_ctrl;
	logic [15:0]         period;
	logic [16:0]         per_next;

	assign wr_ctrl   = WR_EN && (ADDR == wort_pkg::ADDR_WAKE_CTRL);
	assign period    = {hi_q, lo_q};
	assign per_next  = {1'b0, per_q} + 17'h00001;
	// the slow clock is only modelled while the oscillator is powered
	assign slow_tick = (state_q != wort_pkg::ST_OFF)
		&& (div_q == wort_pkg::SLOW_DIV - 10'h001);

	////////////////////////////////////////////////////////////////////////
	// register writes and read data

	// writes take effect at the next edge; read data lags address by one
	always_comb begin
		hi_d      = hi_q;
		lo_d      = lo_q;
		pd_d      = pd_q;
		dly_sel_d = dly_sel_q;
		cal_en_d  = cal_en_q;
		res_d     = res_q;
		if (WR_EN && (ADDR == wort_pkg::ADDR_WAKE_HIGH)) begin
			hi_d = WR_DATA;
		end else if (WR_EN && (ADDR == wort_pkg::ADDR_WAKE_LOW)) begin
			lo_d = WR_DATA;
		end else if (wr_ctrl) begin
			pd_d      = WR_DATA[wort_pkg::PD_BIT];
			dly_sel_d = WR_DATA[wort_pkg::DELAY_LSB +: 3];
			cal_en_d  = WR_DATA[wort_pkg::CAL_BIT];
			res_d     = WR_DATA[wort_pkg::RES_LSB +: 2];
		end
		rd_d = 8'h00; // unmapped offsets read zero
		if (ADDR == wort_pkg::ADDR_WAKE_HIGH) begin
			rd_d = hi_q;
		end else if (ADDR == wort_pkg::ADDR_WAKE_LOW) begin
			rd_d = lo_q;
		end else if (ADDR == wort_pkg::ADDR_WAKE_CTRL) begin
			rd_d = {pd_q, dly_sel_q, cal_en_q, 1'b0, res_q};
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			hi_q      <= wort_pkg::RST_WAKE_HIGH;
			lo_q      <= wort_pkg::RST_WAKE_LOW;
			pd_q      <= wort_pkg::RST_PD;
			dly_sel_q <= wort_pkg::RST_DELAY;
			cal_en_q  <= wort_pkg::RST_CAL_EN;
			res_q     <= wort_pkg::RST_RES;
			rd_q      <= 8'h00;
		end else begin
			hi_q      <= hi_d;
			lo_q      <= lo_d;
			pd_q      <= pd_d;
			dly_sel_q <= dly_sel_d;
			cal_en_q  <= cal_en_d;
			res_q     <= res_d;
			rd_q      <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slow oscillator: power, divider and calibration

	// a falling powerdown bit starts calibration unless it is disabled
	always_comb begin
		state_d = state_q;
		cal_d   = cal_q;
		div_d   = 10'h000;
		if (state_q != wort_pkg::ST_OFF && !slow_tick) begin
			div_d = div_q + 10'h001;
		end
		case (state_q)
			wort_pkg::ST_OFF: begin
				cal_d = 4'h0;
				if (wr_ctrl && !WR_DATA[wort_pkg::PD_BIT]) begin
					if (WR_DATA[wort_pkg::CAL_BIT]) begin
						state_d = wort_pkg::ST_CAL;
					end else begin
						state_d = wort_pkg::ST_RUN;
					end
				end
			end
			wort_pkg::ST_CAL: begin
				if (!cal_en_q) begin
					state_d = wort_pkg::ST_RUN;
				end else if (slow_tick) begin
					cal_d = cal_q + 4'h1;
					if (cal_q == wort_pkg::CAL_PERIODS - 4'h1) begin
						state_d = wort_pkg::ST_RUN;
					end
				end
			end
			wort_pkg::ST_RUN: begin
				cal_d = 4'h0;
			end
			default: begin
				state_d = wort_pkg::ST_OFF;
			end
		endcase
		// powering down wins over any progress in the same cycle
		if (pd_d) begin
			state_d = wort_pkg::ST_OFF;
		end
		osc_d  = (state_d != wort_pkg::ST_OFF);
		busy_d = (state_d == wort_pkg::ST_CAL);
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= wort_pkg::ST_OFF;
			cal_q   <= 4'h0;
			div_q   <= 10'h000;
			osc_q   <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cal_q   <= cal_d;
			div_q   <= div_d;
			osc_q   <= osc_d;
			busy_q  <= busy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wake period timer and receive start delay

	// a period of zero behaves as one count; changing resolution mid
	// count takes effect at once, so a long prescale may end early
	always_comb begin
		pre_d    = pre_q;
		per_d    = per_q;
		ev0_d    = 1'b0;
		ev1_d    = 1'b0;
		d1_act_d = d1_act_q;
		d1_cnt_d = d1_cnt_q;
		d1_lim_d = d1_lim_q;
		if (state_q != wort_pkg::ST_RUN) begin
			pre_d    = 15'h0000;
			per_d    = 16'h0000;
			d1_act_d = 1'b0;
			d1_cnt_d = 6'h00;
		end else if (slow_tick) begin
			if (pre_q >= wort_pkg::wort_pre_last(res_q)) begin
				pre_d = 15'h0000;
				if (per_next >= {1'b0, period}) begin
					per_d = 16'h0000;
					ev0_d = 1'b1;
				end else begin
					per_d = per_next[15:0];
				end
			end else begin
				pre_d = pre_q + 15'h0001;
			end
			if (d1_act_q) begin
				if ({2'b00, d1_cnt_q} + 8'h01 == {2'b00, d1_lim_q}) begin
					ev1_d    = 1'b1;
					d1_act_d = 1'b0;
				end else begin
					d1_cnt_d = d1_cnt_q + 6'h01;
				end
			end
			// a new wake event restarts the delay from zero
			if (ev0_d) begin
				d1_act_d = 1'b1;
				d1_cnt_d = 6'h00;
				d1_lim_d = wort_pkg::wort_delay(dly_sel_q);
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pre_q    <= 15'h0000;
			per_q    <= 16'h0000;
			ev0_q    <= 1'b0;
			ev1_q    <= 1'b0;
			d1_act_q <= 1'b0;
			d1_cnt_q <= 6'h00;
			d1_lim_q <= 6'h30;
		end else begin
			pre_q    <= pre_d;
			per_q    <= per_d;
			ev0_q    <= ev0_d;
			ev1_q    <= ev1_d;
			d1_act_q <= d1_act_d;
			d1_cnt_q <= d1_cnt_d;
			d1_lim_q <= d1_lim_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign RD_DATA        = rd_q;
	assign WAKE_EVENT     = ev0_q;
	assign RX_START_EVENT = ev1_q;
	assign OSC_ON         = osc_q;
	assign CAL_BUSY       = busy_q;

endmodule : wort_top
